// >>> cpu_core.sv
// Processor core model that reaches the EEPROM access registers over the I/O bus.
`timescale 1ns/100ps
`include "eeprom_access_defines.svh"
module cpu_core (
    input  wire logic                     clk,           // CPU clock.
    input  wire logic                     cpu_stall,     // Halt from the access block.
    input  wire logic [7:0]               io_rdata,      // Register read data.
    output logic      [`NV_IO_ADDR_W-1:0] io_addr,       // Register address.
    output logic                          io_wr_en,      // Write request.
    output logic                          io_rd_en,      // Read request.
    output logic      [7:0]               io_wdata,      // Write data.
    output logic                          cpu_int_enable // Global interrupt enable.
);
    // --------------------------------------------------------------
    // Bus accesses
    // --------------------------------------------------------------
    // Idle bus at start; address and data invert once released so stale values never match.
    initial begin
        io_addr = '0;
        io_wr_en = 1'b0;
        io_rd_en = 1'b0;
        io_wdata = 8'h00;
        cpu_int_enable = 1'b0;
    end

    // A halted core issues nothing, so every access first waits out the stall.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        while (cpu_stall === 1'b1) @(posedge clk) #1;
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr_en <= 1'b1;
        @(posedge clk);
        io_wr_en <= 1'b0;
        io_addr <= ~a;
        io_wdata <= ~d;
        #1;
    endtask : wr

    // Read data is taken one cycle after the request edge.
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        while (cpu_stall === 1'b1) @(posedge clk) #1;
        @(posedge clk);
        io_addr <= a;
        io_rd_en <= 1'b1;
        @(posedge clk);
        io_rd_en <= 1'b0;
        io_addr <= ~a;
        #1;
        d = io_rdata;
    endtask : rd

    task automatic set_ie(input logic v);
        @(posedge clk);
        cpu_int_enable <= v;
        #1;
    endtask : set_ie

    // Protected write: poll idle, load, interrupts off, arm, then strobe two cycles later.
    task automatic write_byte(input logic [11:0] a, input logic [7:0] d, input logic rie);
        logic [7:0] c;
        int         n;
        c = 8'h02;
        n = 0;
        while (c[1] !== 1'b0 && n < 64) begin
            rd(`NV_CTRL_OFS, c);
            n++;
        end
        wr(`NV_ADDR_HI_OFS, {4'h0, a[11:8]});
        wr(`NV_ADDR_LO_OFS, a[7:0]);
        wr(`NV_DATA_OFS, d);
        set_ie(1'b0);
        wr(`NV_CTRL_OFS, {4'h0, rie, 3'b100});
        wr(`NV_CTRL_OFS, {4'h0, rie, 3'b010});
    endtask : write_byte
endmodule : cpu_core

// >>> eeprom_access_control.sv
// Data EEPROM access control: address, data and control registers in I/O space.
`timescale 1ns/100ps
`include "eeprom_access_defines.svh"
module eeprom_access_control
    import eeprom_access_pkg::*;
#(
    parameter int ADDR_W       = 12,               // EEPROM address width, 4K bytes.
    parameter int WRITE_CYCLES = `NV_WRITE_CYCLES  // Self-timed write length in clocks.
) (
    input  wire logic                      clk,            // 50 MHz CPU clock.
    input  wire logic                      rst,            // Asynchronous reset, active high.
    input  wire logic [`NV_IO_ADDR_W-1:0]  io_addr,        // I/O register address.
    input  wire logic                      io_wr_en,       // I/O write strobe.
    input  wire logic                      io_rd_en,       // I/O read strobe.
    input  wire logic [7:0]                io_wdata,       // I/O write data.
    input  wire logic                      cpu_int_enable, // Global interrupt enable.
    output logic      [7:0]                io_rdata,       // Registered read data.
    output logic                           cpu_stall,      // Halts the processor.
    output logic                           ready_irq       // Ready interrupt request.
);

    // The counter spans the whole write time; the array spans the whole address range.
    localparam int WCNT_W = $clog2(WRITE_CYCLES + 1);
    localparam int DEPTH  = 1 << ADDR_W;

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    // The high address register carries one to eight bits of the address.
    if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_addr_w
        $error("ADDR_W must lie between 9 and 16");
    end
    // The counter loads one less than the write time, so zero cannot be served.
    if (WRITE_CYCLES < 1) begin : g_bad_write_cycles
        $error("WRITE_CYCLES must be at least one");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] nv_address_reg;
        logic [7:0]        nv_data_reg;
        logic              ready_irq_enable;
        logic              write_arm_bit;
        logic [1:0]        arm_cnt;
        nv_state_t         state;
        logic [WCNT_W-1:0] wcnt;
        logic [ADDR_W-1:0] waddr;
        logic [7:0]        wdata;
        logic              read_strobe_bit;
        logic [2:0]        stall_cnt;
        logic              cpu_stall;
        logic              irq;
        logic [7:0]        rdata;
    } nv_regs_t;

    nv_regs_t   s;
    nv_regs_t   next_s;
    logic [7:0] mem [DEPTH];
    logic       commit;
    logic       wr_ctrl;
    logic       start_write;
    logic       start_read;
    logic [15:0] addr16;
    logic [7:0]  ctrl_view;

    // Decoded accesses and the control register as software sees it.
    assign wr_ctrl     = io_wr_en && (io_addr == `NV_CTRL_OFS);
    // Only a strobe seen while the arm bit is already set starts a write.
    assign start_write = wr_ctrl && io_wdata[`NV_CTRL_WRITE_BIT] && s.write_arm_bit
                         && (s.state == NV_IDLE);
    // A read during a programming cycle is dropped; the array is busy.
    assign start_read  = wr_ctrl && io_wdata[`NV_CTRL_READ_BIT] && (s.state == NV_IDLE);
    assign commit      = (s.state == NV_WRITING) && (s.wcnt == '0);
    assign addr16      = 16'(s.nv_address_reg);
    assign ctrl_view   = {4'h0, s.ready_irq_enable, s.write_arm_bit,
                          (s.state == NV_WRITING), s.read_strobe_bit};

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        // Register writes from the core.
        if (io_wr_en) begin
            case (io_addr)
                `NV_ADDR_LO_OFS: next_s.nv_address_reg[7:0] = io_wdata;
                `NV_ADDR_HI_OFS: next_s.nv_address_reg[ADDR_W-1:8] = io_wdata[ADDR_W-9:0];
                `NV_DATA_OFS:    next_s.nv_data_reg = io_wdata;
                `NV_CTRL_OFS:    next_s.ready_irq_enable = io_wdata[`NV_CTRL_RIE_BIT];
                default:         next_s.nv_data_reg = s.nv_data_reg;
            endcase
        end
        // Arm window: software sets it, hardware drops it four cycles later.
        if (s.write_arm_bit) begin
            if (s.arm_cnt == 2'h0) begin
                next_s.write_arm_bit = 1'b0;
            end else begin
                next_s.arm_cnt = s.arm_cnt - 2'h1;
            end
        end
        if (wr_ctrl && io_wdata[`NV_CTRL_ARM_BIT]) begin
            next_s.write_arm_bit = 1'b1;
            next_s.arm_cnt       = 2'(`NV_ARM_CYCLES - 1);
        end
        // Self-timed write engine.
        case (s.state)
            NV_IDLE: begin
                if (start_write) begin
                    // Address and data are latched so late register edits cannot tear
                    // the byte being programmed.
                    next_s.state = NV_WRITING;
                    next_s.waddr = s.nv_address_reg;
                    next_s.wdata = s.nv_data_reg;
                    next_s.wcnt  = WCNT_W'(WRITE_CYCLES - 1);
                end
            end
            NV_WRITING: begin
                if (commit) begin
                    next_s.state = NV_IDLE;
                end else begin
                    next_s.wcnt = s.wcnt - 1'b1;
                end
            end
            default: next_s.state = NV_IDLE;
        endcase
        // Read strobe fetches at once and shows for a single cycle only.
        next_s.read_strobe_bit = 1'b0;
        if (start_read) begin
            next_s.nv_data_reg     = mem[s.nv_address_reg];
            next_s.read_strobe_bit = 1'b1;
        end
        // Processor stall counter. A start reloads it, so the core is held for the
        // full count even if an earlier stall is still running.
        if (s.stall_cnt != 3'h0) begin
            next_s.stall_cnt = s.stall_cnt - 3'h1;
        end
        if (start_write) begin
            next_s.stall_cnt = 3'(`NV_WRITE_STALL);
        end else if (start_read) begin
            next_s.stall_cnt = 3'(`NV_READ_STALL);
        end
        next_s.cpu_stall = (next_s.stall_cnt != 3'h0);
        // Level request; it drops as soon as a write is busy again.
        next_s.irq = s.ready_irq_enable && cpu_int_enable
                     && (next_s.state == NV_IDLE);
        // Registered read port.
        if (io_rd_en) begin
            case (io_addr)
                `NV_CTRL_OFS:    next_s.rdata = ctrl_view;
                `NV_DATA_OFS:    next_s.rdata = s.nv_data_reg;
                `NV_ADDR_LO_OFS: next_s.rdata = addr16[7:0];
                `NV_ADDR_HI_OFS: next_s.rdata = addr16[15:8];
                default:         next_s.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // The array keeps its contents through reset, as nonvolatile storage does.
    always_ff @(posedge clk) begin
        if (commit) begin
            mem[s.waddr] <= s.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output is a field of the state register, so none has a combinational path.
    assign io_rdata  = s.rdata;
    assign cpu_stall = s.cpu_stall;
    assign ready_irq = s.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // One clock domain, so the whole group shares a default clock and reset guard.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // The window is four edges long; a fresh arm restarts it, so one on the first edge is left out and a later one fails the check.
    arm_window_a: assert property (
        $rose(s.write_arm_bit) && !wr_ctrl
        |-> (s.write_arm_bit && !(wr_ctrl && io_wdata[`NV_CTRL_ARM_BIT]))[*4]
        ##1 !s.write_arm_bit)
        else $error("arm bit did not clear after four cycles");

    // A strobe with the arm bit low must leave the engine idle.
    unarmed_strobe_a: assert property (
        wr_ctrl && io_wdata[`NV_CTRL_WRITE_BIT] && !s.write_arm_bit && s.state == NV_IDLE
        |=> s.state == NV_IDLE)
        else $error("write started without arm");

    // An armed strobe loads one less than the write time into the counter.
    write_start_a: assert property (
        start_write |=> s.state == NV_WRITING && s.wcnt == WCNT_W'(WRITE_CYCLES - 1))
        else $error("armed strobe did not start a timed write");

    // The byte and address programmed are the ones standing at the strobe.
    write_latch_a: assert property (
        start_write |=> s.waddr == $past(s.nv_address_reg)
        && s.wdata == $past(s.nv_data_reg))
        else $error("write did not capture address and data");

    // At the last count the byte lands in the array and the strobe reads zero again.
    write_commit_a: assert property (
        commit |=> s.state == NV_IDLE && mem[$past(s.waddr)] == $past(s.wdata))
        else $error("write did not program byte or clear strobe");

    // The core is held for exactly two cycles after a write starts.
    write_stall_a: assert property (
        start_write |=> cpu_stall[*2] ##1 !cpu_stall)
        else $error("write stall not two cycles");

    // The core is held for exactly four cycles after a read starts.
    read_stall_a: assert property (
        start_read |=> cpu_stall[*4] ##1 !cpu_stall)
        else $error("read stall not four cycles");

    // The fetched byte shows at once and the read strobe drops by itself.
    read_fetch_a: assert property (
        start_read |=> s.nv_data_reg == mem[$past(s.nv_address_reg)]
        && s.read_strobe_bit ##1 !s.read_strobe_bit)
        else $error("read did not fetch byte or strobe stuck");

    // A read strobe while the array is busy is dropped and fetches nothing.
    busy_read_a: assert property (
        wr_ctrl && io_wdata[`NV_CTRL_READ_BIT] && s.state == NV_WRITING
        |=> !s.read_strobe_bit && s.nv_data_reg == $past(s.nv_data_reg))
        else $error("read strobe acted during a write");

    // The request follows the enables one cycle later and the busy state in the same cycle.
    ready_level_a: assert property (
        s.ready_irq_enable && cpu_int_enable && s.state == NV_IDLE && !start_write
        && !(wr_ctrl && !io_wdata[`NV_CTRL_RIE_BIT]) && $stable(cpu_int_enable)
        |=> ready_irq)
        else $error("ready interrupt missing");

    // While the strobe bit reads one the request stays low.
    busy_quiet_a: assert property (
        s.state == NV_WRITING |-> !ready_irq)
        else $error("ready interrupt during write");

    // With global interrupts off no request is raised.
    irq_gated_a: assert property (
        !cpu_int_enable |=> !ready_irq)
        else $error("ready interrupt while interrupts disabled");

    // Bytes written to the data register are held for the next write.
    data_load_a: assert property (
        io_wr_en && io_addr == `NV_DATA_OFS |=> s.nv_data_reg == $past(io_wdata))
        else $error("data register did not take written byte");

    // The low address byte loads whole from the bus.
    address_load_a: assert property (
        io_wr_en && io_addr == `NV_ADDR_LO_OFS |=> s.nv_address_reg[7:0] == $past(io_wdata))
        else $error("low address byte not loaded");

    // Bits of the high byte above the array width are dropped.
    address_high_a: assert property (
        io_wr_en && io_addr == `NV_ADDR_HI_OFS
        |=> s.nv_address_reg[ADDR_W-1:8] == $past(io_wdata[ADDR_W-9:0]))
        else $error("high address byte not loaded");

    // The reserved control bits are wired to zero on the read path.
    reserved_zero_a: assert property (
        io_rd_en && io_addr == `NV_CTRL_OFS |=> io_rdata[7:4] == 4'h0)
        else $error("reserved control bits not zero");

    // Main scenarios: a finished write, a read, an expired arm, a dropped strobe and an armed strobe.
    write_done_c:  cover property (commit);
    read_done_c:   cover property (start_read ##5 !cpu_stall);
    arm_expire_c:  cover property ($fell(s.write_arm_bit) && s.state == NV_IDLE);
    strobe_drop_c: cover property (wr_ctrl && io_wdata[`NV_CTRL_WRITE_BIT] && !s.write_arm_bit);
    arm_strobe_c:  cover property (wr_ctrl && io_wdata[`NV_CTRL_ARM_BIT] ##2 start_write);

endmodule : eeprom_access_control

// >>> eeprom_access_control_bench.sv
// Self-checking bench for the data EEPROM access control block.
`timescale 1ns/100ps
`include "eeprom_access_defines.svh"
module eeprom_access_control_bench;
    localparam logic [5:0] CT = `NV_CTRL_OFS;
    localparam logic [5:0] HI = `NV_ADDR_HI_OFS;
    logic                     clk, rst, io_wr_en, io_rd_en, cpu_int_enable;
    logic                     cpu_stall, ready_irq;
    logic [`NV_IO_ADDR_W-1:0] io_addr;
    logic [7:0]               io_wdata, io_rdata, r;
    logic [5:0]               ofs [5] = '{CT, `NV_DATA_OFS, `NV_ADDR_LO_OFS, HI, 6'h00};
    logic [11:0]              adr [2] = '{12'h0A5, 12'hF5A};
    logic [7:0]               dat [2] = '{8'h3C, 8'hC3};
    int                       fail_count, comparisons, n;

    eeprom_access_control #(.ADDR_W(12), .WRITE_CYCLES(20)) i_eeprom_access_control (
        .clk(clk), .rst(rst), .io_addr(io_addr), .io_wr_en(io_wr_en), .io_rd_en(io_rd_en),
        .io_wdata(io_wdata), .cpu_int_enable(cpu_int_enable), .io_rdata(io_rdata),
        .cpu_stall(cpu_stall), .ready_irq(ready_irq));
    cpu_core i_cpu_core (
        .clk(clk), .cpu_stall(cpu_stall), .io_rdata(io_rdata), .io_addr(io_addr),
        .io_wr_en(io_wr_en), .io_rd_en(io_rd_en), .io_wdata(io_wdata),
        .cpu_int_enable(cpu_int_enable));

    // --------------------------------------------------------------
    // Clock, checks and verdict
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Counts halted cycles over a span longer than any legal stall.
    task automatic stall_count();
        n = 0;
        repeat (8) begin
            if (cpu_stall === 1'b1) n++;
            @(posedge clk) #1;
        end
    endtask : stall_count

    task automatic conclude();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // Whole run needs a few hundred cycles; the limit leaves wide margin.
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end

    // Main sequence: reset state, arm window, writes with interrupt, read-back.
    initial begin
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        foreach (ofs[i]) begin
            i_cpu_core.rd(ofs[i], r);
            chk(r, 8'h00);
        end
        i_cpu_core.wr(CT, 8'hF8);
        i_cpu_core.rd(CT, r);
        chk(r, 8'h08);
        i_cpu_core.set_ie(1'b1);
        @(posedge clk) #1;
        chk({7'h00, ready_irq}, 8'h01);
        i_cpu_core.set_ie(1'b0);
        @(posedge clk) #1;
        chk({7'h00, ready_irq}, 8'h00);
        for (int k = 0; k < 2; k++) begin
            if (k == 1) begin
                i_cpu_core.wr(CT, 8'h0C);
                i_cpu_core.rd(CT, r);
                chk(r, 8'h0C);
                repeat (6) @(posedge clk);
                #1;
            end
            i_cpu_core.wr(CT, 8'h0A);
            stall_count();
            chk(n[7:0], 8'h00);
            i_cpu_core.rd(CT, r);
            chk(r, 8'h08);
        end
        for (int k = 0; k < 2; k++) begin
            i_cpu_core.write_byte(adr[k], dat[k], 1'b1);
            stall_count();
            chk(n[7:0], 8'h02);
            i_cpu_core.set_ie(1'b1);
            @(posedge clk) #1;
            chk({7'h00, ready_irq}, 8'h00);
            i_cpu_core.rd(CT, r);
            chk(r, 8'h0A);
            // A read strobe while the array is busy is dropped and stalls nothing.
            i_cpu_core.wr(CT, 8'h09);
            stall_count();
            chk(n[7:0], 8'h00);
            n = 0;
            while (r[1] !== 1'b0 && n < 64) begin
                i_cpu_core.rd(CT, r);
                n++;
            end
            chk(r, 8'h08);
            @(posedge clk) #1;
            chk({7'h00, ready_irq}, 8'h01);
        end
        // Read back in reverse order; the first address read back is still the one the last write left loaded.
        for (int k = 1; k >= 0; k--) begin
            i_cpu_core.wr(HI, {4'hF, adr[k][11:8]});
            i_cpu_core.rd(HI, r);
            chk(r, {4'h0, adr[k][11:8]});
            i_cpu_core.wr(`NV_ADDR_LO_OFS, adr[k][7:0]);
            i_cpu_core.wr(CT, 8'h09);
            stall_count();
            chk(n[7:0], 8'h04);
            i_cpu_core.rd(`NV_DATA_OFS, r);
            chk(r, dat[k]);
            i_cpu_core.rd(CT, r);
            chk(r, 8'h08);
        end
        conclude();
    end
endmodule : eeprom_access_control_bench

// >>> eeprom_access_defines.svh
// Register offsets, control bit positions, reset values and timing counts for the data EEPROM.
`ifndef EEPROM_ACCESS_DEFINES_SVH
`define EEPROM_ACCESS_DEFINES_SVH

// ------------------------------------------------------------------
// I/O space offsets of the access registers
// ------------------------------------------------------------------
`define NV_IO_ADDR_W        6
`define NV_CTRL_OFS         6'h1C
`define NV_DATA_OFS         6'h1D
`define NV_ADDR_LO_OFS      6'h1E
`define NV_ADDR_HI_OFS      6'h1F

// ------------------------------------------------------------------
// Control register bit positions and reset value
// ------------------------------------------------------------------
`define NV_CTRL_READ_BIT    0
`define NV_CTRL_WRITE_BIT   1
`define NV_CTRL_ARM_BIT     2
`define NV_CTRL_RIE_BIT     3
`define NV_CTRL_RESET       8'h00
`define NV_DATA_RESET       8'h00

// ------------------------------------------------------------------
// Timing: clock period, self-timed write, arm window and stalls
// ------------------------------------------------------------------
`define NV_CLK_PERIOD_NS    20
`define NV_WRITE_TIME_NS    2500000
`define NV_WRITE_CYCLES     ((`NV_WRITE_TIME_NS + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS)
`define NV_ARM_CYCLES       4
`define NV_WRITE_STALL      2
`define NV_READ_STALL       4

`endif

// >>> eeprom_access_pkg.sv
// Types shared by the data EEPROM access logic.
package eeprom_access_pkg;

    // Self-timed write engine states.
    typedef enum logic {
        NV_IDLE,
        NV_WRITING
    } nv_state_t;

endpackage : eeprom_access_pkg
